// [verilog/cdca_pkg.sv]
// constants shared by the class request handler and its notification sender
package cdca_pkg;
  // setup request types and class request codes
  localparam logic [7:0] CDCA_TYPE_OUT = 8'h21;
  localparam logic [7:0] CDCA_TYPE_IN = 8'hA1;
  localparam logic [7:0] CDCA_REQ_SET_CODING = 8'h20;
  localparam logic [7:0] CDCA_REQ_GET_CODING = 8'h21;
  localparam logic [7:0] CDCA_REQ_SET_LINES = 8'h22;
  localparam logic [15:0] CDCA_CODING_LEN = 16'h0007;
  localparam logic [15:0] CDCA_ZERO16 = 16'h0000;
  // line coding structure byte positions
  localparam int CDCA_OFS_RATE = 0;
  localparam int CDCA_OFS_STOP = 4;
  localparam int CDCA_OFS_PARITY = 5;
  localparam int CDCA_OFS_BITS = 6;
  localparam logic [2:0] CDCA_LAST_CODING_BYTE = 3'h6;
  // stop and parity encodings
  localparam logic [7:0] CDCA_STOP_ONE = 8'h00;
  localparam logic [7:0] CDCA_STOP_ONE_HALF = 8'h01;
  localparam logic [7:0] CDCA_STOP_TWO = 8'h02;
  localparam logic [7:0] CDCA_PAR_NONE = 8'h00;
  localparam logic [7:0] CDCA_PAR_ODD = 8'h01;
  localparam logic [7:0] CDCA_PAR_EVEN = 8'h02;
  localparam logic [7:0] CDCA_BITS_7 = 8'h07;
  localparam logic [7:0] CDCA_BITS_8 = 8'h08;
  // supported bit rates
  localparam logic [31:0] CDCA_RATE_1200 = 32'h0000_04B0;
  localparam logic [31:0] CDCA_RATE_2400 = 32'h0000_0960;
  localparam logic [31:0] CDCA_RATE_4800 = 32'h0000_12C0;
  localparam logic [31:0] CDCA_RATE_9600 = 32'h0000_2580;
  localparam logic [31:0] CDCA_RATE_14400 = 32'h0000_3840;
  localparam logic [31:0] CDCA_RATE_19200 = 32'h0000_4B00;
  localparam logic [31:0] CDCA_RATE_38400 = 32'h0000_9600;
  localparam logic [31:0] CDCA_RATE_57600 = 32'h0000_E100;
  localparam logic [31:0] CDCA_RATE_115200 = 32'h0001_C200;
  // reset line coding: 9600 baud, one stop, no parity, 8 bits
  localparam logic [31:0] CDCA_RST_RATE = CDCA_RATE_9600;
  localparam logic [7:0] CDCA_RST_STOP = CDCA_STOP_ONE;
  localparam logic [7:0] CDCA_RST_PARITY = CDCA_PAR_NONE;
  localparam logic [7:0] CDCA_RST_BITS = CDCA_BITS_8;
  // serial state notification
  localparam logic [7:0] CDCA_NOTE_SERIAL_STATE = 8'h20;
  localparam logic [15:0] CDCA_NOTE_LEN = 16'h0002;
  localparam logic [3:0] CDCA_NOTE_LAST_BYTE = 4'h9;
  localparam int CDCA_BIT_OVERRUN = 6;
  localparam int CDCA_BIT_PARITY = 5;
  localparam int CDCA_BIT_FRAMING = 4;
endpackage : cdca_pkg

// [verilog/cdca_notify_tx.sv]
// serial state notification sender: ten bytes onto the interrupt endpoint
`timescale 1ns/100ps
module cdca_notify_tx
  import cdca_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [15:0] bitmap_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic busy_o
);
  logic [3:0] idx_reg;
  logic [15:0] map_reg;
  logic [7:0] byte_next;

  // notification bytes; only the serial state code is ever placed in the header
  always_comb begin
    byte_next = 8'h00;
    unique case (idx_reg)
      4'h0: byte_next = CDCA_TYPE_IN;
      4'h1: byte_next = CDCA_NOTE_SERIAL_STATE;
      4'h6: byte_next = CDCA_NOTE_LEN[7:0];
      4'h7: byte_next = CDCA_NOTE_LEN[15:8];
      4'h8: byte_next = map_reg[7:0];
      4'h9: byte_next = map_reg[15:8];
      default: byte_next = 8'h00; // zero value and index
    endcase
  end

  // sequencer; start while busy is ignored, caller holds it pending
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
      valid_o <= 1'b0;
      idx_reg <= 4'h0;
      map_reg <= 16'h0000;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o <= 1'b1;
        map_reg <= bitmap_i;
        idx_reg <= 4'h0;
      end
    end else if (!valid_o) begin
      valid_o <= 1'b1;
    end else if (ready_i) begin
      valid_o <= 1'b0;
      if (idx_reg == CDCA_NOTE_LAST_BYTE) begin
        busy_o <= 1'b0;
      end else begin
        idx_reg <= idx_reg + 4'h1;
      end
    end
  end

  // data register follows the index so it stands while valid is high
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_o <= 8'h00;
    end else if (busy_o && !valid_o) begin
      data_o <= byte_next;
    end
  end
endmodule : cdca_notify_tx

// [verilog/cdca_request_handler.sv]
// cdc acm class request decoder, line coding store and serial state reporter
`timescale 1ns/100ps
module cdca_request_handler
  import cdca_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  // setup stage from the endpoint engine
  input wire logic setup_valid_i,
  input wire logic [7:0] req_type_i,
  input wire logic [7:0] req_code_i,
  input wire logic [15:0] req_value_i,
  input wire logic [15:0] req_index_i,
  input wire logic [15:0] req_length_i,
  output logic setup_ack_o,
  output logic setup_stall_o,
  // control OUT data stage
  input wire logic out_valid_i,
  input wire logic [7:0] out_data_i,
  // control IN data stage
  output logic in_valid_o,
  output logic [7:0] in_data_o,
  input wire logic in_ready_i,
  // line coding towards the application
  output logic coding_event_o,
  output logic coding_reject_o,
  output logic [31:0] rate_o,
  output logic [7:0] stop_format_o,
  output logic [7:0] parity_o,
  output logic [7:0] data_bits_o,
  // local uart error levels, same clock
  input wire logic uart_overrun_i,
  input wire logic uart_parity_i,
  input wire logic uart_framing_i,
  // interrupt endpoint byte stream
  output logic note_valid_o,
  output logic [7:0] note_data_o,
  input wire logic note_ready_i
);
  typedef enum logic [1:0] {
    CDCA_IDLE = 2'b00,
    CDCA_SET_DATA = 2'b01,
    CDCA_GET_DATA = 2'b10
  } cdca_state_e;

  cdca_state_e state_reg;
  logic [2:0] idx_reg;
  logic [55:0] shadow_reg;
  logic [55:0] cur_coding;
  logic is_set;
  logic is_get;
  logic is_lines;
  logic coding_ok;
  logic commit_reg;
  logic err_any;
  logic err_prev_reg;
  logic note_pend_reg;
  logic [15:0] map_reg;
  logic [15:0] map_now;
  logic note_busy;
  logic note_start;

  // request decode on the setup fields
  assign is_set = (req_type_i == CDCA_TYPE_OUT) && (req_code_i == CDCA_REQ_SET_CODING) &&
                  (req_value_i == CDCA_ZERO16) && (req_index_i == CDCA_ZERO16) &&
                  (req_length_i == CDCA_CODING_LEN);
  assign is_get = (req_type_i == CDCA_TYPE_IN) && (req_code_i == CDCA_REQ_GET_CODING) &&
                  (req_length_i == CDCA_CODING_LEN);
  // value is not inspected: reserved bits or handshake levels never refuse it
  assign is_lines = (req_type_i == CDCA_TYPE_OUT) && (req_code_i == CDCA_REQ_SET_LINES) &&
                    (req_index_i == CDCA_ZERO16) && (req_length_i == CDCA_ZERO16);

  // current settings laid out as the seven-byte structure, little endian
  assign cur_coding = {data_bits_o, parity_o, stop_format_o, rate_o};

  // supported subset check on the collected structure
  always_comb begin
    logic [31:0] r;
    logic rate_ok;
    r = shadow_reg[8*CDCA_OFS_RATE +: 32];
    rate_ok = (r == CDCA_RATE_1200) || (r == CDCA_RATE_2400) || (r == CDCA_RATE_4800) ||
              (r == CDCA_RATE_9600) || (r == CDCA_RATE_14400) || (r == CDCA_RATE_19200) ||
              (r == CDCA_RATE_38400) || (r == CDCA_RATE_57600) || (r == CDCA_RATE_115200);
    // one and a half stop bits decodes but is not supported
    coding_ok = rate_ok &&
                ((shadow_reg[8*CDCA_OFS_STOP +: 8] == CDCA_STOP_ONE) ||
                 (shadow_reg[8*CDCA_OFS_STOP +: 8] == CDCA_STOP_TWO)) &&
                ((shadow_reg[8*CDCA_OFS_PARITY +: 8] == CDCA_PAR_NONE) ||
                 (shadow_reg[8*CDCA_OFS_PARITY +: 8] == CDCA_PAR_ODD) ||
                 (shadow_reg[8*CDCA_OFS_PARITY +: 8] == CDCA_PAR_EVEN)) &&
                ((shadow_reg[8*CDCA_OFS_BITS +: 8] == CDCA_BITS_7) ||
                 (shadow_reg[8*CDCA_OFS_BITS +: 8] == CDCA_BITS_8));
  end

  // control transfer sequencer; a new setup always restarts it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= CDCA_IDLE;
      idx_reg <= 3'h0;
    end else if (setup_valid_i) begin
      idx_reg <= 3'h0;
      if (is_set) begin
        state_reg <= CDCA_SET_DATA;
      end else if (is_get) begin
        state_reg <= CDCA_GET_DATA;
      end else begin
        state_reg <= CDCA_IDLE;
      end
    end else begin
      unique case (state_reg)
        CDCA_IDLE: begin
          idx_reg <= 3'h0;
        end
        CDCA_SET_DATA: begin
          if (out_valid_i) begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == CDCA_LAST_CODING_BYTE) begin
              state_reg <= CDCA_IDLE;
            end
          end
        end
        CDCA_GET_DATA: begin
          if (in_valid_o && in_ready_i) begin
            idx_reg <= idx_reg + 3'h1;
            if (idx_reg == CDCA_LAST_CODING_BYTE) begin
              state_reg <= CDCA_IDLE;
            end
          end
        end
        default: state_reg <= CDCA_IDLE;
      endcase
    end
  end

  // setup answer pulses; control-line request is acked with no effect
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      setup_ack_o <= 1'b0;
      setup_stall_o <= 1'b0;
    end else begin
      setup_ack_o <= setup_valid_i && (is_set || is_get || is_lines);
      setup_stall_o <= setup_valid_i && !(is_set || is_get || is_lines);
    end
  end

  // data stage bytes collect into a shadow so a partial stage never disturbs settings
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shadow_reg <= 56'h00_0000_0000_0000;
    end else if ((state_reg == CDCA_SET_DATA) && out_valid_i && !setup_valid_i) begin
      shadow_reg[8*idx_reg +: 8] <= out_data_i;
    end
  end

  // commit one cycle after the seventh byte; unsupported settings keep the old ones
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_o <= CDCA_RST_RATE;
      stop_format_o <= CDCA_RST_STOP;
      parity_o <= CDCA_RST_PARITY;
      data_bits_o <= CDCA_RST_BITS;
      coding_event_o <= 1'b0;
      coding_reject_o <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= (state_reg == CDCA_SET_DATA) && out_valid_i && !setup_valid_i &&
                    (idx_reg == CDCA_LAST_CODING_BYTE);
      coding_event_o <= commit_reg && coding_ok;
      coding_reject_o <= commit_reg && !coding_ok;
      if (commit_reg && coding_ok) begin
        rate_o <= shadow_reg[8*CDCA_OFS_RATE +: 32];
        stop_format_o <= shadow_reg[8*CDCA_OFS_STOP +: 8];
        parity_o <= shadow_reg[8*CDCA_OFS_PARITY +: 8];
        data_bits_o <= shadow_reg[8*CDCA_OFS_BITS +: 8];
      end
    end
  end

  // in data: byte is loaded with valid low, then stands until taken
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_valid_o <= 1'b0;
      in_data_o <= 8'h00;
    end else if (setup_valid_i || (state_reg != CDCA_GET_DATA)) begin
      in_valid_o <= 1'b0;
    end else if (!in_valid_o) begin
      in_valid_o <= 1'b1;
      in_data_o <= cur_coding[8*idx_reg +: 8];
    end else if (in_ready_i) begin
      in_valid_o <= 1'b0;
    end
  end

  // error bitmap; only the three supported bits can ever be set
  always_comb begin
    map_now = 16'h0000;
    map_now[CDCA_BIT_OVERRUN] = uart_overrun_i;
    map_now[CDCA_BIT_PARITY] = uart_parity_i;
    map_now[CDCA_BIT_FRAMING] = uart_framing_i;
  end
  assign err_any = uart_overrun_i || uart_parity_i || uart_framing_i;
  assign note_start = note_pend_reg && !note_busy;

  // clean-to-error edge arms one notification; a fresh edge wins over the start clear
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_prev_reg <= 1'b0;
      note_pend_reg <= 1'b0;
      map_reg <= 16'h0000;
    end else begin
      err_prev_reg <= err_any;
      if (err_any && !err_prev_reg) begin
        note_pend_reg <= 1'b1;
        map_reg <= map_now;
      end else if (note_start) begin
        note_pend_reg <= 1'b0;
      end
    end
  end

  cdca_notify_tx u_notify (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .start_i(note_start),
    .bitmap_i(map_reg),
    .ready_i(note_ready_i),
    .valid_o(note_valid_o),
    .data_o(note_data_o),
    .busy_o(note_busy)
  );
endmodule : cdca_request_handler

// [dv/cdca_request_handler_sva.sv]
// checker: setup answers, line coding outputs and notification framing
`timescale 1ns/100ps
module cdca_request_handler_sva
  import cdca_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic setup_valid_i,
  input wire logic [7:0] req_type_i,
  input wire logic [7:0] req_code_i,
  input wire logic [15:0] req_value_i,
  input wire logic [15:0] req_index_i,
  input wire logic [15:0] req_length_i,
  input wire logic setup_ack_o,
  input wire logic setup_stall_o,
  input wire logic coding_event_o,
  input wire logic [31:0] rate_o,
  input wire logic [7:0] stop_format_o,
  input wire logic [7:0] parity_o,
  input wire logic [7:0] data_bits_o,
  input wire logic uart_overrun_i,
  input wire logic uart_parity_i,
  input wire logic uart_framing_i,
  input wire logic note_valid_o,
  input wire logic [7:0] note_data_o,
  input wire logic note_ready_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // byte position inside the ten-byte notification
  logic [3:0] pos_reg;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) pos_reg <= 4'h0;
    else if (note_valid_o && note_ready_i) pos_reg <= (pos_reg == 4'h9) ? 4'h0 : pos_reg + 4'h1;
  end
  // decoded request kinds, only valid with setup_valid_i
  wire setq = req_type_i == 8'h21 && req_code_i == 8'h20 && req_value_i == 16'h0000 && req_index_i == 16'h0000;
  wire getq = req_type_i == 8'hA1 && req_code_i == 8'h21 && req_length_i == 16'h0007;
  wire linq = req_type_i == 8'h21 && req_code_i == 8'h22 && req_index_i == 16'h0000 && req_length_i == 16'h0000;
  wire err = uart_overrun_i || uart_parity_i || uart_framing_i;
  AST_SET_ACK: assert property (
    setup_valid_i && setq && req_length_i == 16'h0007 |=> setup_ack_o && !setup_stall_o)
    else $error("set coding not acknowledged");
  AST_GET_ACK: assert property (setup_valid_i && getq |=> setup_ack_o)
    else $error("get coding not acknowledged");
  AST_LINES_ACK: assert property (setup_valid_i && linq |=> setup_ack_o)
    else $error("control line request not acknowledged");
  AST_STALL: assert property (
    setup_valid_i && !(req_code_i inside {8'h20, 8'h21, 8'h22}) |=> setup_stall_o && !setup_ack_o)
    else $error("unknown request not stalled");
  AST_CODING_HOLD: assert property (
    !coding_event_o |-> $stable({rate_o, stop_format_o, parity_o, data_bits_o}))
    else $error("coding changed without commit");
  AST_CODING_LEGAL: assert property (
    data_bits_o inside {8'h07, 8'h08} && stop_format_o inside {8'h00, 8'h02} &&
    parity_o <= 8'h02 && rate_o inside {32'h0000_04B0, 32'h0000_0960, 32'h0000_12C0, 32'h0000_2580, 32'h0000_3840,
    32'h0000_4B00, 32'h0000_9600, 32'h0000_E100, 32'h0001_C200})
    else $error("unsupported coding held");
  AST_NOTE_HOLD: assert property (note_valid_o && !note_ready_i |=> note_valid_o && $stable(note_data_o))
    else $error("notification byte dropped while stalled");
  AST_NOTE_HDR: assert property (
    note_valid_o && pos_reg < 4'h8 |-> note_data_o == (pos_reg == 4'h0 ? 8'hA1 :
    pos_reg == 4'h1 ? 8'h20 : pos_reg == 4'h6 ? 8'h02 : 8'h00))
    else $error("notification header byte wrong");
  AST_NOTE_MAP: assert property (
    note_valid_o && pos_reg >= 4'h8 |-> (note_data_o & (pos_reg == 4'h8 ? 8'h8F : 8'hFF)) == 8'h00)
    else $error("unsupported bitmap bit set");
  AST_NOTE_TRIG: assert property ($rose(err) && !note_valid_o && pos_reg == 4'h0 |-> ##[1:8] note_valid_o)
    else $error("error rise not notified");
  cover property (coding_event_o);
  cover property (setup_stall_o);
  cover property (note_valid_o && note_ready_i && pos_reg == 4'h9);
endmodule : cdca_request_handler_sva

// [dv/cdca_host_model.sv]
// host side model: takes control in and notification bytes, with optional stalls
`timescale 1ns/100ps
module cdca_host_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  input wire logic note_valid_i,
  input wire logic [7:0] note_data_i,
  output logic in_ready_o,
  output logic note_ready_o
);
  logic [7:0] in_q[$];
  logic [7:0] note_q[$];
  logic [1:0] tick_reg;
  // slow host is ready one cycle in three, so holds are exercised
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) tick_reg <= 2'h0;
    else tick_reg <= (tick_reg == 2'h2) ? 2'h0 : tick_reg + 2'h1;
  end
  assign in_ready_o = !slow_i || tick_reg == 2'h0;
  assign note_ready_o = !slow_i || tick_reg == 2'h1;
  // collect every byte the host takes
  always @(posedge clock_i) begin
    if (in_valid_i && in_ready_o) in_q.push_back(in_data_i);
    if (note_valid_i && note_ready_o) note_q.push_back(note_data_i);
  end
endmodule : cdca_host_model

// [dv/tb.sv]
// testbench: request handler against a reference coding model and host model
`timescale 1ns/100ps
module tb;
  import cdca_pkg::*;
  logic clock_i, rstn_i, setup_valid_i, out_valid_i, uart_overrun_i, uart_parity_i, uart_framing_i, slow;
  logic [7:0] req_type_i, req_code_i, out_data_i, note_data_o, in_data_o, stop_format_o, parity_o, data_bits_o;
  logic [15:0] req_value_i, req_index_i, req_length_i;
  logic [31:0] rate_o, lf;
  logic setup_ack_o, setup_stall_o, in_valid_o, in_ready_i, coding_event_o, coding_reject_o, note_valid_o, note_ready_i;
  int n_fail, num_checks, i, k;
  int m[7];
  int b[7];
  int rates[9] = '{1200, 2400, 4800, 9600, 14400, 19200, 38400, 57600, 115200};
  cdca_request_handler cdca_request_handler_i (.clock_i(clock_i), .rstn_i(rstn_i), .setup_valid_i(setup_valid_i),
    .req_type_i(req_type_i), .req_code_i(req_code_i), .req_value_i(req_value_i), .req_index_i(req_index_i),
    .req_length_i(req_length_i), .setup_ack_o(setup_ack_o), .setup_stall_o(setup_stall_o), .out_valid_i(out_valid_i),
    .out_data_i(out_data_i), .in_valid_o(in_valid_o), .in_data_o(in_data_o), .in_ready_i(in_ready_i),
    .coding_event_o(coding_event_o), .coding_reject_o(coding_reject_o), .rate_o(rate_o), .stop_format_o(stop_format_o),
    .parity_o(parity_o), .data_bits_o(data_bits_o), .uart_overrun_i(uart_overrun_i), .uart_parity_i(uart_parity_i),
    .uart_framing_i(uart_framing_i), .note_valid_o(note_valid_o), .note_data_o(note_data_o), .note_ready_i(note_ready_i));
  cdca_host_model cdca_host_model_i (.clock_i(clock_i), .rstn_i(rstn_i), .slow_i(slow), .in_valid_i(in_valid_o),
    .in_data_i(in_data_o), .note_valid_i(note_valid_o), .note_data_i(note_data_o), .in_ready_o(in_ready_i),
    .note_ready_o(note_ready_i));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  function automatic logic [31:0] lfsr_next(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // bounded wait step; running out ends the run as a failure
  task automatic tick(inout int c);
    @(posedge clock_i);
    #1;
    c++;
    if (c > 100) begin
      n_fail++;
      final_report();
    end
  endtask : tick
  task automatic setup(input logic [7:0] t, c, input logic [15:0] v, x, l, input logic ok);
    @(posedge clock_i);
    setup_valid_i <= 1'b1;
    req_type_i <= t;
    req_code_i <= c;
    req_value_i <= v;
    req_index_i <= x;
    req_length_i <= l;
    @(posedge clock_i);
    setup_valid_i <= 1'b0;
    #1;
    chk(setup_ack_o, ok, "ack");
    chk(setup_stall_o, !ok, "stall");
  endtask : setup
  task automatic cmp_coding();
    chk(rate_o, m[0] | (m[1] << 8) | (m[2] << 16) | (m[3] << 24), "rate");
    chk(stop_format_o, m[4], "stop");
    chk(parity_o, m[5], "parity");
    chk(data_bits_o, m[6], "bits");
  endtask : cmp_coding
  // one set-coding with seven bytes, then read the coding back
  task automatic set_coding(input int r, st, pa, bi);
    logic ok;
    ok = (st == 0 || st == 2) && pa <= 2 && (bi == 7 || bi == 8) && (r inside {rates});
    for (k = 0; k < 4; k++) b[k] = (r >> (8 * k)) & 255;
    b[4] = st;
    b[5] = pa;
    b[6] = bi;
    setup(8'h21, 8'h20, 16'h0000, 16'h0000, 16'h0007, 1'b1);
    for (k = 0; k < 7; k++) begin
      @(posedge clock_i);
      out_valid_i <= 1'b1;
      out_data_i <= 8'(b[k]);
    end
    @(posedge clock_i);
    out_valid_i <= 1'b0;
    k = 0;
    while (coding_event_o !== 1'b1 && coding_reject_o !== 1'b1) tick(k);
    chk(coding_event_o, ok, "event");
    chk(coding_reject_o, !ok, "reject");
    if (ok) m = b;
    cmp_coding();
    setup(8'hA1, 8'h21, 16'h0000, 16'h0000, 16'h0007, 1'b1);
    k = 0;
    while (cdca_host_model_i.in_q.size() < 7) tick(k);
    for (k = 0; k < 7; k++) chk(cdca_host_model_i.in_q.pop_front(), m[k], "get");
  endtask : set_coding
  task automatic note_expect(input int map);
    int h[10];
    h = '{8'hA1, 8'h20, 0, 0, 0, 0, 2, 0, map, 0};
    k = 0;
    while (cdca_host_model_i.note_q.size() < 10) tick(k);
    for (k = 0; k < 10; k++) chk(cdca_host_model_i.note_q.pop_front(), h[k], "note");
  endtask : note_expect
  initial begin
    {rstn_i, setup_valid_i, out_valid_i, uart_overrun_i, uart_parity_i, uart_framing_i, slow} = 7'h00;
    {req_type_i, req_code_i, req_value_i, req_index_i, req_length_i, out_data_i} = 72'h0;
    lf = 32'hef00_461e;
    n_fail = 0;
    num_checks = 0;
    m = '{128, 37, 0, 0, 0, 0, 8};
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    #1;
    cmp_coding();
    // every stop, parity and bit-length code, legal rates and random rates
    for (i = 0; i < 18; i++) begin
      lf = lfsr_next(lf);
      slow <= i[0];
      set_coding((i % 5 == 4) ? int'(lf[16:0]) : rates[i % 9], i % 3, (i / 3) % 4, 5 + i % 4);
    end
    lf = lfsr_next(lf);
    setup(8'h21, 8'h22, {14'h0000, lf[1:0]}, 16'h0000, 16'h0000, 1'b1);
    @(posedge clock_i);
    out_valid_i <= 1'b1;
    @(posedge clock_i);
    out_valid_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    cmp_coding();
    setup(8'h21, 8'h20, 16'h0000, 16'h0000, 16'h0006, 1'b0);
    setup(8'h21, 8'h23, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    slow <= 1'b1;
    // each error alone, then errors changing among themselves
    for (i = 0; i < 3; i++) begin
      @(posedge clock_i);
      {uart_overrun_i, uart_parity_i, uart_framing_i} <= 3'b100 >> i;
      note_expect(8'h40 >> i);
      @(posedge clock_i);
      {uart_overrun_i, uart_parity_i, uart_framing_i} <= 3'b111;
      repeat (30) @(posedge clock_i);
      chk(cdca_host_model_i.note_q.size(), 0, "resend");
      {uart_overrun_i, uart_parity_i, uart_framing_i} <= 3'b000;
    end
    final_report();
  end
endmodule : tb
bind cdca_request_handler cdca_request_handler_sva cdca_request_handler_sva_i (.clock_i(clock_i), .rstn_i(rstn_i),
  .setup_valid_i(setup_valid_i), .req_type_i(req_type_i), .req_code_i(req_code_i), .req_value_i(req_value_i),
  .req_index_i(req_index_i), .req_length_i(req_length_i), .setup_ack_o(setup_ack_o), .setup_stall_o(setup_stall_o),
  .coding_event_o(coding_event_o), .rate_o(rate_o), .stop_format_o(stop_format_o), .parity_o(parity_o),
  .data_bits_o(data_bits_o), .uart_overrun_i(uart_overrun_i), .uart_parity_i(uart_parity_i),
  .uart_framing_i(uart_framing_i), .note_valid_o(note_valid_o), .note_data_o(note_data_o), .note_ready_i(note_ready_i));
